// ### core/dmr_ctrl.sv
`timescale 1ns/10ps
// How it works
// - controller holds clock 200 us first
// - nop with cke high 400 ns
// - program extended two then three
// - extended one dll on, ocd zero
// - base write with dll reset
// - precharge, two refreshes, base rewrite
// - ocd default then exit after 200
// - every register programmed before use
// - each write supplies all fields
// - register writes keep array contents
// - writes only precharged, cke high
// - mode command stores address by bank
// - burst length, order, cas latency fields
// - test mode low, dll reset, recovery
// - recovery field rounded up cycles
// - extended one field layout
// - self refresh disables then resets dll
// - 200 clocks lock before read
// - read strobe disables data mask
// - adjust keeps additive latency
// - extended two only bit seven
// - extended three all zero
module dmr_ctrl
   import dmr_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        start_i,
   input  wire logic [13:0] base_op_i,
   input  wire logic [13:0] ext1_op_i,
   input  wire logic        srf_ht_i,
   output logic             done_o,
   dmr_link_if.ctrl         link
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_STABLE = 4'h1, S_NOP = 4'h2, S_PRE1 = 4'h3,
      S_EXT2 = 4'h4, S_EXT3 = 4'h5, S_EXT1 = 4'h6, S_DLLR = 4'h7,
      S_PRE2 = 4'h8, S_REF = 4'h9, S_BASE = 4'ha, S_LOCK = 4'hb,
      S_OCDD = 4'hc, S_OCDX = 4'hd, S_DONE = 4'he
   } dmr_state_t;
   typedef struct packed {
      dmr_state_t  state;
      logic [15:0] cnt;
      logic [1:0]  div;
      logic        lclk;
      logic        cke;
      logic [3:0]  cmd;
      logic [2:0]  bank;
      logic [13:0] addr;
      logic        done;
      logic [1:0]  refs;
      logic [7:0]  since_rst;
      logic [13:0] base_m;
      logic [13:0] base_s;
      logic [13:0] ext1_m;
      logic [13:0] ext1_s;
      logic        srf_m;
      logic        srf_s;
   } dmr_ctrl_t;
   dmr_ctrl_t st_r, st_nxt;
   logic start_s;
   dmr_sync u_sync (.clk_i(core_clk_i), .rst_b_i(rst_b_i), .d_i(start_i), .q_o(start_s));
   // one link cycle is CLK_DIV core cycles; commands change with the falling link edge so
   // the far end samples them settled, half a link period later, at the rising one
   logic edge_w;
   assign edge_w = (st_r.div == 2'(CLK_DIV - 1));
   always_comb begin
      st_nxt      = st_r;
      st_nxt.div  = st_r.div + 2'h1;
      // operating words are quasi-static: two stages, then read only long after start
      // rises, so they must be held steady from start until done
      st_nxt.base_m = base_op_i;
      st_nxt.base_s = st_r.base_m;
      st_nxt.ext1_m = ext1_op_i;
      st_nxt.ext1_s = st_r.ext1_m;
      st_nxt.srf_m  = srf_ht_i;
      st_nxt.srf_s  = st_r.srf_m;
      if (st_r.div == 2'(CLK_DIV / 2 - 1)) st_nxt.lclk = 1'b1;
      if (edge_w) begin
         st_nxt.lclk = 1'b0;
         st_nxt.cmd  = CMD_NOP;
         st_nxt.bank = 3'h0;
         st_nxt.addr = 14'h0000;
         if (st_r.cnt != 16'h0000) st_nxt.cnt = st_r.cnt - 16'h0001;
         if (st_r.since_rst != 8'hff) st_nxt.since_rst = st_r.since_rst + 8'h01;
         unique case (st_r.state)
            S_IDLE: if (start_s) begin
               st_nxt.state = S_STABLE;
               st_nxt.cnt   = 16'(STABLE_CYC);
            end
            S_STABLE: if (st_r.cnt == 16'h0000) begin
               st_nxt.cke   = 1'b1;
               st_nxt.state = S_NOP;
               st_nxt.cnt   = 16'(NOP_CYC);
            end
            S_NOP: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd      = CMD_PRE;
               st_nxt.addr[10] = 1'b1;
               st_nxt.state    = S_EXT2;
               st_nxt.cnt      = 16'(MRD_CYC);
            end
            S_EXT2: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_EXT2;
               st_nxt.addr  = EXT2_OP;
               st_nxt.addr[E2_SRF_HT] = st_r.srf_s;
               st_nxt.state = S_EXT3;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_EXT3: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_EXT3;
               st_nxt.addr  = EXT3_OP;
               st_nxt.state = S_EXT1;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_EXT1: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_EXT1;
               st_nxt.addr  = st_r.ext1_s;
               st_nxt.addr[E1_DLLDIS] = 1'b0;
               st_nxt.addr[E1_OCD_LO +: 3] = OCD_EXIT;
               st_nxt.addr[A13] = 1'b0;
               st_nxt.state = S_DLLR;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_DLLR: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_BASE;
               st_nxt.addr  = st_r.base_s;
               st_nxt.addr[BM_TM] = 1'b0;
               st_nxt.addr[BM_WR_LO +: 3] = 3'(WR_CYC);
               st_nxt.addr[BM_DLLRST] = 1'b1;
               st_nxt.addr[A13] = 1'b0;
               st_nxt.since_rst = 8'h00;
               st_nxt.state = S_PRE2;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_PRE2: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd      = CMD_PRE;
               st_nxt.addr[10] = 1'b1;
               st_nxt.refs     = 2'h0;
               st_nxt.state    = S_REF;
               st_nxt.cnt      = 16'(MRD_CYC);
            end
            S_REF: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd  = CMD_REF;
               st_nxt.refs = st_r.refs + 2'h1;
               st_nxt.cnt  = 16'(MRD_CYC);
               if (st_r.refs == 2'(MIN_REF - 1)) st_nxt.state = S_BASE;
            end
            S_BASE: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_BASE;
               st_nxt.addr  = st_r.base_s;
               st_nxt.addr[BM_TM] = 1'b0;
               st_nxt.addr[BM_DLLRST] = 1'b0;
               st_nxt.addr[BM_WR_LO +: 3] = 3'(WR_CYC);
               st_nxt.addr[A13] = 1'b0;
               st_nxt.state = S_LOCK;
            end
            // wait out the lock time before calibration and reads
            S_LOCK: if (st_r.since_rst >= 8'(LOCK_CYC)) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_EXT1;
               st_nxt.addr  = st_r.ext1_s;
               st_nxt.addr[E1_DLLDIS] = 1'b0;
               st_nxt.addr[E1_OCD_LO +: 3] = OCD_DEFAULT;
               st_nxt.addr[A13] = 1'b0;
               st_nxt.state = S_OCDD;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_OCDD: if (st_r.cnt == 16'h0000) begin
               st_nxt.cmd   = CMD_MODE;
               st_nxt.bank  = SEL_EXT1;
               st_nxt.addr  = st_r.ext1_s;
               st_nxt.addr[E1_DLLDIS] = 1'b0;
               st_nxt.addr[E1_OCD_LO +: 3] = OCD_EXIT;
               st_nxt.addr[A13] = 1'b0;
               st_nxt.state = S_OCDX;
               st_nxt.cnt   = 16'(MRD_CYC);
            end
            S_OCDX: if (st_r.cnt == 16'h0000) begin
               st_nxt.done  = 1'b1;
               st_nxt.state = S_DONE;
            end
            S_DONE: ;
            default: st_nxt.state = S_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r      <= '0;
         st_r.cmd  <= CMD_NOP;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign link.link_clk = st_r.lclk;
   assign link.cke      = st_r.cke;
   assign link.cmd      = st_r.cmd;
   assign link.bank     = st_r.bank;
   assign link.addr     = st_r.addr;
   assign done_o        = st_r.done;
endmodule : dmr_ctrl

// ### include/dmr_pkg.sv
package dmr_pkg;
   // command encoding {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP      = 4'h7;
   localparam logic [3:0] CMD_DESEL    = 4'h8;
   localparam logic [3:0] CMD_PRE      = 4'h2;
   localparam logic [3:0] CMD_REF      = 4'h1;
   localparam logic [3:0] CMD_MODE     = 4'h0;
   localparam logic [3:0] CMD_READ     = 4'h5;
   localparam logic [3:0] CMD_SREF     = 4'h1;
   localparam int         ADDR_W       = 14;
   localparam int         BANK_W       = 3;
   // bank select of the four configuration registers
   localparam logic [2:0] SEL_BASE     = 3'h0;
   localparam logic [2:0] SEL_EXT1     = 3'h1;
   localparam logic [2:0] SEL_EXT2     = 3'h2;
   localparam logic [2:0] SEL_EXT3     = 3'h3;
   // field positions
   localparam int         BM_BL_LO     = 0;
   localparam int         BM_BT        = 3;
   localparam int         BM_CL_LO     = 4;
   localparam int         BM_TM        = 7;
   localparam int         BM_DLLRST    = 8;
   localparam int         BM_WR_LO     = 9;
   localparam int         E1_DLLDIS    = 0;
   localparam int         E1_DRV       = 1;
   localparam int         E1_RTT0      = 2;
   localparam int         E1_AL_LO     = 3;
   localparam int         E1_RTT1      = 6;
   localparam int         E1_OCD_LO    = 7;
   localparam int         E1_STRB_DIS  = 10;
   localparam int         E1_RSTRB_EN  = 11;
   localparam int         E2_SRF_HT    = 7;
   localparam logic [2:0] OCD_EXIT     = 3'h0;
   localparam logic [2:0] OCD_DEFAULT  = 3'h7;
   localparam logic [2:0] BL_4         = 3'h2;
   localparam logic [2:0] BL_8         = 3'h3;
   localparam int         A13          = 13;
   // timing, waits assume an 80 ns link clock; the bench link clock period is 400 ns
   localparam int         LINK_NS      = 80;
   localparam int         STABLE_US    = 200;
   localparam int         STABLE_CYC   = (STABLE_US * 1000 + LINK_NS - 1) / LINK_NS;
   localparam int         NOP_NS       = 400;
   localparam int         NOP_CYC      = (NOP_NS + LINK_NS - 1) / LINK_NS;
   localparam int         LOCK_CYC     = 200;
   localparam int         MRD_CYC      = 2;
   localparam int         MIN_REF      = 2;
   localparam int         CLK_DIV      = 4;
   localparam int         CORE_NS      = 100;
   localparam int         TCK_NS       = CORE_NS * CLK_DIV;
   // write recovery time is a plain default; set it for the memory in use
   localparam int         WR_NS        = 15;
   localparam int         WR_CYC       = (WR_NS + TCK_NS - 1) / TCK_NS;
   localparam int         CNT_W        = 12;
   // default operating words
   localparam logic [13:0] BASE_OP     = 14'h0632;
   localparam logic [13:0] EXT1_OP     = 14'h0000;
   localparam logic [13:0] EXT2_OP     = 14'h0000;
   localparam logic [13:0] EXT3_OP     = 14'h0000;
endpackage : dmr_pkg

// ### include/dmr_link_if.sv
`timescale 1ns/10ps
interface dmr_link_if;
   logic       link_clk;
   logic       cke;
   logic [3:0] cmd;
   logic [2:0] bank;
   logic [13:0] addr;
   modport ctrl (output link_clk, output cke, output cmd, output bank, output addr);
   modport mem  (input link_clk, input cke, input cmd, input bank, input addr);
endinterface : dmr_link_if

// ### core/dmr_sync.sv
`timescale 1ns/10ps
module dmr_sync
   import dmr_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic [1:0] s_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= 2'h0;
      end else begin
         s_r <= {s_r[0], d_i};
      end
   end
   assign q_o = s_r[1];
endmodule : dmr_sync

// ### core/dmr_mem.sv
`timescale 1ns/10ps
module dmr_mem
   import dmr_pkg::*;
(
   dmr_link_if.mem       link,
   input  wire logic     rst_b_i,
   output logic [13:0]   base_o,
   output logic [13:0]   ext1_o,
   output logic [13:0]   ext2_o,
   output logic [13:0]   ext3_o,
   output logic [2:0]    burst_len_o,
   output logic          burst_ilv_o,
   output logic [2:0]    cas_lat_o,
   output logic [2:0]    wr_rec_o,
   output logic [2:0]    add_lat_o,
   output logic [2:0]    ocd_mode_o,
   output logic          dll_on_o,
   output logic          dll_locked_o,
   output logic          mask_en_o,
   output logic          read_early_o,
   output logic          programmed_o,
   output logic          self_ref_o
);
   typedef struct packed {
      logic [13:0] base;
      logic [13:0] ext1;
      logic [13:0] ext2;
      logic [13:0] ext3;
      logic [3:0]  written;
      logic [7:0]  lock_cnt;
      logic        locked;
      logic        self_ref;
      logic        read_early;
      logic        dll_on;
      logic        programmed;
      logic        mask_en;
   } dmr_mem_t;
   dmr_mem_t st_r, st_nxt;
   logic     cke_q;
   assign cke_q = link.cke;
   always_comb begin
      st_nxt = st_r;
      if (!st_r.locked && st_r.lock_cnt != 8'h00) begin
         st_nxt.lock_cnt = st_r.lock_cnt - 8'h01;
         if (st_r.lock_cnt == 8'h01) st_nxt.locked = 1'b1;
      end
      if (st_r.self_ref) begin
         if (cke_q) begin
            st_nxt.self_ref = 1'b0;
            st_nxt.locked   = 1'b0;
            st_nxt.lock_cnt = 8'(LOCK_CYC);
         end
      end else if (cke_q) begin
         unique case (link.cmd)
            CMD_MODE: begin
               // only the configuration store changes, never the array
               unique case (link.bank)
                  SEL_BASE: begin
                     st_nxt.base       = link.addr;
                     st_nxt.written[0] = 1'b1;
                     if (link.addr[BM_DLLRST] && !st_r.ext1[E1_DLLDIS]) begin
                        st_nxt.locked   = 1'b0;
                        st_nxt.lock_cnt = 8'(LOCK_CYC);
                     end
                  end
                  SEL_EXT1: begin
                     st_nxt.ext1       = link.addr;
                     st_nxt.written[1] = 1'b1;
                     if (link.addr[E1_DLLDIS]) st_nxt.locked = 1'b0;
                  end
                  SEL_EXT2: begin
                     st_nxt.ext2       = link.addr;
                     st_nxt.written[2] = 1'b1;
                  end
                  SEL_EXT3: begin
                     st_nxt.ext3       = link.addr;
                     st_nxt.written[3] = 1'b1;
                  end
                  default: ;
               endcase
            end
            CMD_READ: if (!st_r.locked) st_nxt.read_early = 1'b1;
            default: ;
         endcase
      end else if (link.cmd == CMD_SREF) begin
         // refresh with cke low enters self refresh, dll off
         st_nxt.self_ref = 1'b1;
         st_nxt.locked   = 1'b0;
         st_nxt.lock_cnt = 8'h00;
      end
      // status bits are registered from the next state so they track it without lag
      st_nxt.dll_on     = !st_nxt.ext1[E1_DLLDIS] && !st_nxt.self_ref;
      st_nxt.programmed = &st_nxt.written;
      st_nxt.mask_en    = !st_nxt.ext1[E1_RSTRB_EN];
   end
   always_ff @(posedge link.link_clk or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign base_o       = st_r.base;
   assign ext1_o       = st_r.ext1;
   assign ext2_o       = st_r.ext2;
   assign ext3_o       = st_r.ext3;
   assign burst_len_o  = st_r.base[BM_BL_LO +: 3];
   assign burst_ilv_o  = st_r.base[BM_BT];
   assign cas_lat_o    = st_r.base[BM_CL_LO +: 3];
   assign wr_rec_o     = st_r.base[BM_WR_LO +: 3];
   assign add_lat_o    = st_r.ext1[E1_AL_LO +: 3];
   assign ocd_mode_o   = st_r.ext1[E1_OCD_LO +: 3];
   assign dll_on_o     = st_r.dll_on;
   assign dll_locked_o = st_r.locked;
   assign mask_en_o    = st_r.mask_en;
   assign read_early_o = st_r.read_early;
   assign programmed_o = st_r.programmed;
   assign self_ref_o   = st_r.self_ref;
endmodule : dmr_mem

// ### verification/dmr_link_properties.sv
`timescale 1ns/10ps
module dmr_link_properties
   import dmr_pkg::*;
(
   input  wire logic        link_clk,
   input  wire logic        rst_b_i,
   input  wire logic        cke,
   input  wire logic [3:0]  cmd,
   input  wire logic [2:0]  bank,
   input  wire logic [13:0] addr
);
   logic        wr_mode;
   logic        busy;
   logic [12:0] cyc_r;
   logic [8:0]  lock_r;

   assign wr_mode = cke && (cmd == CMD_MODE);
   assign busy    = cke && (cmd != CMD_NOP) && (cmd != CMD_DESEL);

   // both counters saturate so a long idle run cannot wrap them back under the limit
   always_ff @(posedge link_clk or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cyc_r  <= '0;
         lock_r <= '0;
      end else begin
         if (cyc_r != '1) begin
            cyc_r <= cyc_r + 13'h1;
         end
         if (wr_mode && bank == SEL_BASE && addr[BM_DLLRST]) begin
            lock_r <= 9'h1;
         end else if (lock_r != '0 && lock_r != '1) begin
            lock_r <= lock_r + 9'h1;
         end
      end
   end

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_b_i);

   property p_stable;   busy |-> cyc_r >= STABLE_CYC; endproperty
   property p_nop_wait; $rose(cke) |-> (cmd == CMD_NOP || cmd == CMD_DESEL)[*5]; endproperty
   property p_one_shot; busy |=> cmd == CMD_NOP; endproperty
   property p_mode_cke; cmd == CMD_MODE |-> cke; endproperty
   property p_bank_sel; wr_mode |-> bank <= SEL_EXT3; endproperty
   property p_ext1;     wr_mode && bank == SEL_EXT1 |-> !addr[E1_DLLDIS] && !addr[A13]; endproperty
   property p_base;     wr_mode && bank == SEL_BASE |-> !addr[BM_TM] && !addr[A13]; endproperty
   property p_ext2;     wr_mode && bank == SEL_EXT2 |-> (addr & 14'h3f7f) == 14'h0; endproperty
   property p_ext3;     wr_mode && bank == SEL_EXT3 |-> addr == 14'h0; endproperty
   property p_pre_all;  cke && cmd == CMD_PRE |-> addr[10]; endproperty
   property p_lock;
      wr_mode && bank == SEL_EXT1 && addr[9:7] == OCD_DEFAULT |-> lock_r >= LOCK_CYC;
   endproperty

   a_stable:   assert property (p_stable)   else $error("command before clock stable wait");
   a_nop_wait: assert property (p_nop_wait) else $error("no nop run after clock enable");
   a_one_shot: assert property (p_one_shot) else $error("command held longer than one clock");
   a_mode_cke: assert property (p_mode_cke) else $error("mode write with clock enable low");
   a_bank_sel: assert property (p_bank_sel) else $error("mode write to undefined register");
   a_ext1:     assert property (p_ext1)     else $error("ext one write with dll off");
   a_base:     assert property (p_base)     else $error("base write with test mode set");
   a_ext2:     assert property (p_ext2)     else $error("ext two reserved bit set");
   a_ext3:     assert property (p_ext3)     else $error("ext three not zero");
   a_pre_all:  assert property (p_pre_all)  else $error("precharge without all banks");
   a_lock:     assert property (p_lock)     else $error("ocd default before lock wait");

   c_dll_reset: cover property (wr_mode && bank == SEL_BASE && addr[BM_DLLRST]);
   c_ocd_dflt:  cover property (wr_mode && bank == SEL_EXT1 && addr[9:7] == OCD_DEFAULT);
   c_ext2_hot:  cover property (wr_mode && bank == SEL_EXT2 && addr[E2_SRF_HT]);
endmodule : dmr_link_properties

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
   import dmr_pkg::*;
   logic        core_clk_i;
   logic        rst_b_i;
   logic        start_i;
   logic        srf_ht_i;
   logic        done_o;
   logic [13:0] base_op_i;
   logic [13:0] ext1_op_i;
   logic [13:0] base_o, ext1_o, ext2_o, ext3_o;
   logic [2:0]  bl_o, cl_o, wr_o, al_o, ocd_o;
   logic        ilv_o, dll_on_o, lock_o, mask_o, early_o, prog_o, sref_o;
   int          err_total, samples_checked, lcyc;
   int          q_cmd[$], q_bank[$], q_t[$];
   logic [13:0] q_addr[$];

   dmr_link_if link_if();
   dmr_ctrl dmr_ctrl_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
      .base_op_i(base_op_i), .ext1_op_i(ext1_op_i), .srf_ht_i(srf_ht_i), .done_o(done_o),
      .link(link_if.ctrl));
   dmr_mem dmr_mem_i (.link(link_if.mem), .rst_b_i(rst_b_i), .base_o(base_o), .ext1_o(ext1_o),
      .ext2_o(ext2_o), .ext3_o(ext3_o), .burst_len_o(bl_o), .burst_ilv_o(ilv_o),
      .cas_lat_o(cl_o), .wr_rec_o(wr_o), .add_lat_o(al_o), .ocd_mode_o(ocd_o),
      .dll_on_o(dll_on_o), .dll_locked_o(lock_o), .mask_en_o(mask_o), .read_early_o(early_o),
      .programmed_o(prog_o), .self_ref_o(sref_o));
   dmr_link_properties dmr_link_properties_i (.link_clk(link_if.link_clk), .rst_b_i(rst_b_i),
      .cke(link_if.cke), .cmd(link_if.cmd), .bank(link_if.bank), .addr(link_if.addr));

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // sampled at the rising link edge, half a link period after the command word changed
   always @(posedge link_if.link_clk) begin
      lcyc++;
      if (rst_b_i && link_if.cke && link_if.cmd != CMD_NOP && link_if.cmd != CMD_DESEL) begin
         q_cmd.push_back(int'(link_if.cmd));
         q_bank.push_back(int'(link_if.bank));
         q_addr.push_back(link_if.addr);
         q_t.push_back(lcyc);
      end
   end

   task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic run_init(input int cut);
      logic [13:0] b, e;
      logic [13:0] msk[11], val[11];
      int          ops[11] = '{2, 0, 0, 0, 0, 2, 1, 1, 0, 0, 0};
      int          bnk[11] = '{0, 2, 3, 1, 0, 0, 0, 0, 0, 1, 1};
      // every init starts from reset, so a cut run cannot find the sequencer already done
      rst_b_i = 1'b0;
      repeat (5) @(negedge core_clk_i);
      rst_b_i = 1'b1;
      b = {2'b00, 3'(WR_CYC), 2'b00, 3'($urandom_range(6, 3)), 1'($urandom),
           ($urandom % 2) ? BL_8 : BL_4};
      e = {2'b00, 2'($urandom), 3'b000, 1'($urandom), 3'($urandom_range(5, 0)), 2'($urandom), 1'b0};
      // a random recovery field on the input must be replaced by the rounded-up count
      base_op_i = b | {2'b00, 3'($urandom), 9'h000};
      ext1_op_i = e;
      srf_ht_i  = 1'($urandom);
      q_cmd.delete();
      q_bank.delete();
      q_addr.delete();
      q_t.delete();
      start_i = 1'b1;
      if (cut > 0) begin
         repeat (cut) @(negedge core_clk_i);
         rst_b_i = 1'b0;
         start_i = 1'b0;
         repeat (5) @(negedge core_clk_i);
         chk({base_o[0], ext1_o[0], prog_o, lock_o, done_o, link_if.cke}, 14'h0);
         rst_b_i = 1'b1;
         return;
      end
      for (int i = 0; i < 16000 && done_o !== 1'b1; i++) @(negedge core_clk_i);
      repeat (8) @(negedge core_clk_i);
      start_i = 1'b0;
      msk = '{14'h0400, 14'h3fff, 14'h3fff, 14'h2381, 14'h2180, 14'h0400, 14'h0, 14'h0,
              14'h3fff, 14'h3fff, 14'h3fff};
      val = '{14'h0400, 14'(srf_ht_i) << 7, 14'h0, 14'h0, 14'h0100, 14'h0400, 14'h0, 14'h0,
              b, e | 14'h0380, e};
      chk(14'(q_cmd.size()), 14'd11);
      if (q_cmd.size() == 11) begin
         for (int i = 0; i < 11; i++) begin
            chk(14'(q_cmd[i]), 14'(ops[i]));
            chk(14'((ops[i] == 0) ? q_bank[i] : 0), 14'(bnk[i]));
            chk(q_addr[i] & msk[i], val[i]);
         end
         chk(14'(q_t[9] - q_t[4] >= LOCK_CYC), 14'd1);
      end
      chk(base_o, b);
      chk(ext1_o, e);
      chk(ext2_o, 14'(srf_ht_i) << 7);
      chk(ext3_o, 14'h0);
      chk({bl_o, ilv_o, cl_o, wr_o}, {b[2:0], b[3], b[6:4], b[11:9]});
      chk({al_o, ocd_o, dll_on_o}, {e[5:3], OCD_EXIT, 1'b1});
      chk(mask_o, !e[E1_RSTRB_EN]);
      chk({lock_o, prog_o, sref_o, early_o, done_o}, 14'h19);
   endtask : run_init

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // three inits take about 32400 core clocks
   initial begin
      repeat (50000) @(posedge core_clk_i);
      err_total++;
      print_verdict;
   end

   initial begin
      rst_b_i         = 1'b0;
      start_i         = 1'b0;
      srf_ht_i        = 1'b0;
      base_op_i       = 14'h0;
      ext1_op_i       = 14'h0;
      err_total       = 0;
      samples_checked = 0;
      lcyc            = 0;
      void'($urandom(9614));
      repeat (5) @(negedge core_clk_i);
      rst_b_i = 1'b1;
      run_init(0);
      // reset lands inside the lock wait, then a clean retry must still work
      run_init(10500);
      run_init(0);
      print_verdict;
   end
endmodule : tb
